// file: pkg/wwdt_pkg.sv
// Package for the windowed watchdog: offsets, fields, reset values, types.
// Assumes a 32-bit register port and one system clock.
package wwdt_pkg;

    localparam logic [3:0]  WWDT_OFS_RESTART   = 4'h0;
    localparam logic [3:0]  WWDT_OFS_MODE      = 4'h4;
    localparam logic [3:0]  WWDT_OFS_STATUS    = 4'h8;

    localparam logic [7:0]  WWDT_KEY           = 8'hA5;
    localparam int          WWDT_KEY_LSB       = 24;
    localparam int          WWDT_RESTART_BIT   = 0;

    localparam logic [31:0] WWDT_MODE_RESET    = 32'h3FFF2FFF;
    localparam int          WWDT_RELOAD_LSB    = 0;
    localparam int          WWDT_FIEN_BIT      = 12;
    localparam int          WWDT_RSTEN_BIT     = 13;
    localparam int          WWDT_RPROC_BIT     = 14;
    localparam int          WWDT_DIS_BIT       = 15;
    localparam int          WWDT_DELTA_LSB     = 16;
    localparam int          WWDT_DBGHLT_BIT    = 28;
    localparam int          WWDT_IDLEHLT_BIT   = 29;
    localparam int          WWDT_UNF_BIT       = 0;
    localparam int          WWDT_ERR_BIT       = 1;

    localparam int          WWDT_CNT_W         = 12;
    localparam int          WWDT_DIV_RATIO     = 128;
    localparam logic [6:0]  WWDT_DIV_LAST      = 7'h7F;

    typedef struct packed {
        logic [3:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } wwdt_req_t;

    typedef struct packed {
        logic                  idle_halt;
        logic                  debug_halt;
        logic [WWDT_CNT_W-1:0] restart_window_delta;
        logic                  timer_disable;
        logic                  processor_only_reset;
        logic                  fault_reset_enable;
        logic                  fault_irq_enable;
        logic [WWDT_CNT_W-1:0] counter_reload_value;
    } wwdt_mode_t;

endpackage : wwdt_pkg

// file: verilog/wwdt_top.sv
// Windowed watchdog core with key-protected restart and write-once mode.
// Assumes an asynchronous slow clock, debug and idle levels from pins, all synchronised here.
//
// What this block does
// (R1) Restart write needs key 0xA5, else dropped
// (R2) Keyed write with restart bit restarts
// (R3) Mode reload field loads 12-bit counter
// (R4) Restart accepted only when counter <= delta
// (R5) Early restart flags error, no restart
// (R6) Irq enable routes faults to interrupt
// (R7) Reset enable routes faults to reset
// (R8) Processor-only select picks reset kind
// (R9) Debug halt stops counter in debug
// (R10) Idle halt stops counter when idle
// (R11) Disable bit turns the timer off
// (R12) Underflow flag sticky until status read
// (R13) Error flag sticky until status read
// (R14) Slow clock /128 tick, divider restarts
// (R15) Underflow sets flag, asserts fault output
// (R16) Status read clears flags and outputs
// (R17) Mode register writable once, reloads counter
// (R18) Disabled counter holds, no underflow
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module wwdt_top
    import wwdt_pkg::*;
(
    input  wire logic        I_CLOCK,
    input  wire logic        I_RSTN,
    input  wire logic [3:0]  I_ADDR,
    input  wire logic [31:0] I_WDATA,
    input  wire logic        I_WR,
    input  wire logic        I_RD,
    input  wire logic        I_SLOW_CLK,
    input  wire logic        I_DEBUG,
    input  wire logic        I_IDLE,
    output logic      [31:0] O_RDATA,
    output logic             O_IRQ,
    output logic             O_FAULT_ALL,
    output logic             O_FAULT_PROC,
    output logic      [11:0] O_COUNT
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; slow clock edge seen after two flops
    logic [2:0] slow_r;
    logic [1:0] dbg_r;
    logic [1:0] idle_r;

    always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            slow_r <= 3'h0;
            dbg_r  <= 2'h0;
            idle_r <= 2'h0;
        end else begin
            slow_r <= {slow_r[1:0], I_SLOW_CLK};
            dbg_r  <= {dbg_r[0], I_DEBUG};
            idle_r <= {idle_r[0], I_IDLE};
        end
    end

    logic slow_rise;
    assign slow_rise = slow_r[1] & ~slow_r[2];

    ////////////////////////////////////////////////////////////////////////
    // Register port decode
    wwdt_req_t req;
    assign req = '{addr: I_ADDR, wdata: I_WDATA, wr: I_WR, rd: I_RD};

    logic key_ok;
    logic restart_wr;
    logic mode_wr;
    logic status_rd;
    assign key_ok     = req.wdata[WWDT_KEY_LSB +: $bits(WWDT_KEY)] == WWDT_KEY;  // [R1]
    assign restart_wr = req.wr && req.addr == WWDT_OFS_RESTART && key_ok
                        && req.wdata[WWDT_RESTART_BIT];                  // [R2]
    assign status_rd  = req.rd && req.addr == WWDT_OFS_STATUS;

    ////////////////////////////////////////////////////////////////////////
    // Mode register, write-once
    wwdt_mode_t mode_r, mode_nxt;
    logic       locked_r, locked_nxt;

    assign mode_wr = req.wr && req.addr == WWDT_OFS_MODE && !locked_r;   // [R17]

    always_comb begin
        mode_nxt   = mode_r;
        locked_nxt = locked_r;
        if (mode_wr) begin
            mode_nxt   = '{idle_halt:            req.wdata[WWDT_IDLEHLT_BIT],
                           debug_halt:           req.wdata[WWDT_DBGHLT_BIT],
                           restart_window_delta: req.wdata[WWDT_DELTA_LSB +: WWDT_CNT_W],
                           timer_disable:        req.wdata[WWDT_DIS_BIT],
                           processor_only_reset: req.wdata[WWDT_RPROC_BIT],
                           fault_reset_enable:   req.wdata[WWDT_RSTEN_BIT],
                           fault_irq_enable:     req.wdata[WWDT_FIEN_BIT],
                           counter_reload_value: req.wdata[WWDT_RELOAD_LSB +: WWDT_CNT_W]};
            locked_nxt = 1'b1;                                           // [R17]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Counter, divider and status
    logic [WWDT_CNT_W-1:0] cnt_r, cnt_nxt;
    logic [6:0]            div_r, div_nxt;
    logic                  unf_r, unf_nxt;
    logic                  err_r, err_nxt;
    logic                  in_window;
    logic                  halted;
    logic                  tick;
    logic                  underflow;
    logic                  early;

    assign in_window = cnt_r <= mode_r.restart_window_delta;             // [R4]
    assign early     = restart_wr && !in_window;                         // [R5]
    // Error check runs even when disabled
    assign halted    = mode_r.timer_disable                              // [R11] [R18]
                       || (mode_r.debug_halt && dbg_r[1])                // [R9]
                       || (mode_r.idle_halt && idle_r[1]);               // [R10]
    assign tick      = slow_rise && !halted && div_r == WWDT_DIV_LAST;   // [R14]
    assign underflow = tick && cnt_r == '0;

    always_comb begin
        cnt_nxt = cnt_r;
        div_nxt = div_r;
        if (mode_wr) begin
            cnt_nxt = req.wdata[WWDT_RELOAD_LSB +: WWDT_CNT_W];          // [R17]
            div_nxt = '0;
        end else if (restart_wr && in_window) begin
            cnt_nxt = mode_r.counter_reload_value;                       // [R3] [R4]
            div_nxt = '0;                                                // [R14]
        end else if (slow_rise && !halted) begin
            div_nxt = div_r + 7'h01;                                     // [R14]
            if (tick) begin
                cnt_nxt = underflow ? mode_r.counter_reload_value : cnt_r - 12'h001;  // [R3]
            end
        end
    end

    // Set wins over the read clear
    always_comb begin
        unf_nxt = (unf_r && !status_rd) || underflow;                    // [R12] [R15] [R16]
        err_nxt = (err_r && !status_rd) || early;                        // [R13] [R16]
    end

    always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            mode_r   <= wwdt_mode_t'(WWDT_MODE_RESET[$bits(wwdt_mode_t)-1:0]);
            locked_r <= 1'b0;
            cnt_r    <= WWDT_MODE_RESET[WWDT_CNT_W-1:0];
            div_r    <= '0;
            unf_r    <= 1'b0;
            err_r    <= 1'b0;
        end else begin
            mode_r   <= mode_nxt;
            locked_r <= locked_nxt;
            cnt_r    <= cnt_nxt;
            div_r    <= div_nxt;
            unf_r    <= unf_nxt;
            err_r    <= err_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, all registered
    logic [31:0] rdata_nxt;
    logic        irq_nxt;
    logic        fall_nxt;
    logic        fproc_nxt;
    logic        fault_any;

    assign fault_any = unf_nxt || err_nxt;

    always_comb begin
        rdata_nxt = 32'h0;
        if (req.rd) begin
            case (req.addr)
                WWDT_OFS_MODE: rdata_nxt = {2'h0, mode_r};
                WWDT_OFS_STATUS: begin
                    rdata_nxt[WWDT_UNF_BIT] = unf_r;
                    rdata_nxt[WWDT_ERR_BIT] = err_r;
                end
                default: rdata_nxt = 32'h0;
            endcase
        end
        irq_nxt   = mode_r.fault_irq_enable && fault_any;                // [R6] [R16]
        fall_nxt  = mode_r.fault_reset_enable && !mode_r.processor_only_reset && fault_any;  // [R7] [R8]
        fproc_nxt = mode_r.fault_reset_enable && fault_any;              // [R7] [R8] [R15]
    end

    always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            O_RDATA      <= 32'h0;
            O_IRQ        <= 1'b0;
            O_FAULT_ALL  <= 1'b0;
            O_FAULT_PROC <= 1'b0;
            O_COUNT      <= WWDT_MODE_RESET[WWDT_CNT_W-1:0];
        end else begin
            O_RDATA      <= rdata_nxt;
            O_IRQ        <= irq_nxt;
            O_FAULT_ALL  <= fall_nxt;
            O_FAULT_PROC <= fproc_nxt;
            O_COUNT      <= cnt_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    a_bad_key_ignored: assert property (@(posedge I_CLOCK) disable iff (!I_RSTN) // [R1]
        (req.wr && req.addr == WWDT_OFS_RESTART && !key_ok && !underflow && !tick)
        |=> (cnt_r == $past(cnt_r)))
        else $error("restart with bad key changed counter");

    a_restart_reload: assert property (@(posedge I_CLOCK) disable iff (!I_RSTN) // [R2]
        (restart_wr && in_window) |=> (cnt_r == mode_r.counter_reload_value && div_r == '0))
        else $error("accepted restart did not reload");

    a_restart_bit_zero: assert property (@(posedge I_CLOCK) disable iff (!I_RSTN) // [R2]
        (req.wr && req.addr == WWDT_OFS_RESTART && key_ok && !req.wdata[WWDT_RESTART_BIT] && !tick && !err_r)
        |=> (cnt_r == $past(cnt_r) && !err_r))
        else $error("restart with bit clear had an effect");

    a_reload_value: assert property (@(posedge I_CLOCK) disable iff (!I_RSTN) // [R3]
        (underflow && !mode_wr) |=> (cnt_r == mode_r.counter_reload_value))
        else $error("underflow did not reload counter");

    a_window_no_error: assert property (@(posedge I_CLOCK) disable iff (!I_RSTN) // [R4]
        (restart_wr && in_window && !err_r) |=> !err_r)
        else $error("restart inside window flagged error");

    a_early_error: assert property (@(posedge I_CLOCK) disable iff (!I_RSTN) // [R5]
        early |=> err_r)
        else $error("early restart did not set error");

    a_early_no_reload: assert property (@(posedge I_CLOCK) disable iff (!I_RSTN) // [R5]
        (early && !tick) |=> (cnt_r == $past(cnt_r)))
        else $error("early restart moved counter");

    a_underflow_flag: assert property (@(posedge I_CLOCK) disable iff (!I_RSTN) // [R12]
        underflow |=> unf_r)
        else $error("underflow flag not set");

    a_unf_sticky: assert property (@(posedge I_CLOCK) disable iff (!I_RSTN) // [R12]
        (unf_r && !status_rd) |=> unf_r)
        else $error("underflow flag dropped without read");

    a_err_sticky: assert property (@(posedge I_CLOCK) disable iff (!I_RSTN) // [R13]
        (err_r && !status_rd) |=> err_r)
        else $error("error flag dropped without read");

    a_read_clears: assert property (@(posedge I_CLOCK) disable iff (!I_RSTN) // [R16]
        (status_rd && !underflow && !early) |=> (!unf_r && !err_r && !O_IRQ && !O_FAULT_ALL && !O_FAULT_PROC))
        else $error("status read did not clear");

    a_irq_on_fault: assert property (@(posedge I_CLOCK) disable iff (!I_RSTN) // [R6]
        (underflow && mode_r.fault_irq_enable) |=> O_IRQ)
        else $error("underflow did not raise interrupt");

    a_irq_gate: assert property (@(posedge I_CLOCK) disable iff (!I_RSTN) // [R6]
        O_IRQ |-> $past(mode_r.fault_irq_enable))
        else $error("interrupt without enable");

    a_reset_gate: assert property (@(posedge I_CLOCK) disable iff (!I_RSTN) // [R7]
        (O_FAULT_PROC || O_FAULT_ALL) |-> $past(mode_r.fault_reset_enable))
        else $error("reset request without enable");

    a_proc_only: assert property (@(posedge I_CLOCK) disable iff (!I_RSTN) // [R8]
        O_FAULT_ALL |-> (O_FAULT_PROC && !$past(mode_r.processor_only_reset)))
        else $error("full reset despite processor-only");

    a_full_reset: assert property (@(posedge I_CLOCK) disable iff (!I_RSTN) // [R8]
        (early && mode_r.fault_reset_enable && !mode_r.processor_only_reset) |=> O_FAULT_ALL)
        else $error("fault did not request full reset");

    a_debug_stop: assert property (@(posedge I_CLOCK) disable iff (!I_RSTN) // [R9]
        (mode_r.debug_halt && dbg_r[1] && !mode_wr && !restart_wr) |=> ($stable(cnt_r) && $stable(div_r)))
        else $error("counter ran in debug halt");

    a_idle_stop: assert property (@(posedge I_CLOCK) disable iff (!I_RSTN) // [R10]
        (mode_r.idle_halt && idle_r[1] && !mode_wr && !restart_wr) |=> ($stable(cnt_r) && $stable(div_r)))
        else $error("counter ran in idle halt");

    a_disabled_div: assert property (@(posedge I_CLOCK) disable iff (!I_RSTN) // [R11]
        (mode_r.timer_disable && !mode_wr && !restart_wr) |=> $stable(div_r))
        else $error("divider ran while disabled");

    a_div_count: assert property (@(posedge I_CLOCK) disable iff (!I_RSTN) // [R14]
        (slow_rise && !halted && !mode_wr && !restart_wr) |=> (div_r == $past(div_r) + 7'h01))
        else $error("divider missed a slow edge");

    a_tick_step: assert property (@(posedge I_CLOCK) disable iff (!I_RSTN) // [R14]
        (tick && !underflow && !mode_wr && !restart_wr) |=> (cnt_r == $past(cnt_r) - 12'h001))
        else $error("counter did not step on tick");

    a_fault_output: assert property (@(posedge I_CLOCK) disable iff (!I_RSTN) // [R15]
        (underflow && mode_r.fault_reset_enable) |=> O_FAULT_PROC)
        else $error("underflow did not request reset");

    a_disabled_hold: assert property (@(posedge I_CLOCK) disable iff (!I_RSTN) // [R18]
        (mode_r.timer_disable && !mode_wr && !restart_wr) |=> $stable(cnt_r))
        else $error("disabled counter moved");

    a_mode_once: assert property (@(posedge I_CLOCK) disable iff (!I_RSTN) // [R17]
        (locked_r && req.wr && req.addr == WWDT_OFS_MODE) |=> $stable(mode_r))
        else $error("mode changed after lock");

endmodule : wwdt_top

`default_nettype wire

// file: sim/wwdt_partner.sv
// Partner model: the reset controller that listens to the fault outputs.
// Assumes level fault outputs, sampled on the system clock.
`timescale 1ns/1ps
`default_nettype none
module wwdt_partner (
    input  wire logic       i_clk,
    input  wire logic       i_rstn,
    input  wire logic       i_fault_all,
    input  wire logic       i_fault_proc,
    output logic      [7:0] o_sys_resets,
    output logic      [7:0] o_proc_resets
);
    logic all_q;
    logic proc_q;
    // Counts requests only; pulling reset here would cut the test short
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            all_q         <= 1'b0;
            proc_q        <= 1'b0;
            o_sys_resets  <= 8'h00;
            o_proc_resets <= 8'h00;
        end else begin
            all_q  <= i_fault_all;
            proc_q <= i_fault_proc;
            if (i_fault_all && !all_q) o_sys_resets <= o_sys_resets + 8'h01;
            if (i_fault_proc && !proc_q) o_proc_resets <= o_proc_resets + 8'h01;
        end
    end
endmodule : wwdt_partner
`default_nettype wire

// file: sim/wwdt_top_tb.sv
// Testbench for the windowed watchdog: register tasks and directed tests.
// Assumes the partner model beside it and a 10 MHz system clock.
`timescale 1ns/1ps
`default_nettype none
module wwdt_top_tb;
    localparam logic [31:0] MODE_A = 32'h30047008;
    localparam logic [31:0] MODE_B = 32'h0004A008;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic [3:0]  addr = 4'h0;
    logic [31:0] wdata = 32'h00000000;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        slow = 1'b0;
    logic        dbg = 1'b0;
    logic        idle = 1'b0;
    logic        slow_run = 1'b0;
    logic [1:0]  slow_div = 2'h0;
    logic [31:0] rdata;
    logic        irq;
    logic        f_all;
    logic        f_proc;
    logic [11:0] count;
    logic [7:0]  n_sys;
    logic [7:0]  n_proc;
    int          mismatches = 0;
    int          checks_done = 0;
    int          cycles = 0;
    int          i;
    ////////////////////////////////////////////////////////////////////////////
    always #50 clk = ~clk;
    // Slow clock stands still unless a test runs it; 8 system cycles a period
    always @(posedge clk) begin
        if (slow_run) begin
            slow_div <= slow_div + 2'h1;
            if (slow_div == 2'h3) slow <= ~slow;
        end
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            mismatches++;
            report_and_stop();
        end
    end
    wwdt_top wwdt_top_inst (.I_CLOCK(clk), .I_RSTN(rstn), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
        .I_RD(rd), .I_SLOW_CLK(slow), .I_DEBUG(dbg), .I_IDLE(idle), .O_RDATA(rdata), .O_IRQ(irq),
        .O_FAULT_ALL(f_all), .O_FAULT_PROC(f_proc), .O_COUNT(count));
    wwdt_partner wwdt_partner_inst (.i_clk(clk), .i_rstn(rstn), .i_fault_all(f_all),
        .i_fault_proc(f_proc), .o_sys_resets(n_sys), .o_proc_resets(n_proc));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp, input string what);
        @(posedge clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata, exp, what);
    endtask : rd_chk
    task automatic run_slow(input int n);
        slow_run <= 1'b1;
        tick(n);
        slow_run <= 1'b0;
    endtask : run_slow
    task automatic do_reset();
        rstn <= 1'b0;
        tick(8);
        rstn <= 1'b1;
        tick(1);
    endtask : do_reset
    task automatic report_and_stop();
        $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : report_and_stop
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        do_reset();
        chk({20'h00000, count}, 32'h00000FFF, "count at reset");
        rd_chk(4'h4, 32'h3FFF2FFF, "mode reset");
        rd_chk(4'h8, 32'h00000000, "status reset");
        rd_chk(4'hC, 32'h00000000, "unmapped");
        $display("test reset values done");
        wr_reg(4'h4, MODE_A);
        tick(2);
        chk({20'h00000, count}, 32'h00000008, "mode load");
        wr_reg(4'h4, 32'h00000FFF);
        rd_chk(4'h4, MODE_A, "second mode write");
        wr_reg(4'h0, 32'h5A000001);
        rd_chk(4'h8, 32'h00000000, "bad key");
        wr_reg(4'h0, 32'hA5000000);
        rd_chk(4'h8, 32'h00000000, "restart bit zero");
        wr_reg(4'h0, 32'hA5000001);
        tick(3);
        chk({29'h0, irq, f_all, f_proc}, 32'h00000005, "early error outputs");
        rd_chk(4'h8, 32'h00000002, "error flag");
        tick(2);
        chk({29'h0, irq, f_all, f_proc}, 32'h00000000, "cleared outputs");
        rd_chk(4'h8, 32'h00000000, "flag cleared");
        $display("test window error done");
        dbg <= 1'b1;
        run_slow(1600);
        chk({20'h00000, count}, 32'h00000008, "debug halt");
        dbg  <= 1'b0;
        idle <= 1'b1;
        run_slow(1600);
        chk({20'h00000, count}, 32'h00000008, "idle halt");
        idle <= 1'b0;
        $display("test halts done");
        slow_run <= 1'b1;
        for (i = 0; i < 9000 && count > 12'h004; i++) tick(1);
        slow_run <= 1'b0;
        wr_reg(4'h0, 32'hA5000001);
        tick(2);
        chk({20'h00000, count}, 32'h00000008, "restart in window");
        rd_chk(4'h8, 32'h00000000, "no error in window");
        $display("test window restart done");
        slow_run <= 1'b1;
        for (i = 0; i < 12000 && f_proc !== 1'b1; i++) tick(1);
        slow_run <= 1'b0;
        chk({20'h00000, count}, 32'h00000008, "reload on underflow");
        chk({29'h0, irq, f_all, f_proc}, 32'h00000005, "underflow outputs");
        rd_chk(4'h8, 32'h00000001, "underflow flag");
        chk({16'h0000, n_sys, n_proc}, 32'h00000002, "partner proc resets");
        $display("test underflow done");
        wr_reg(4'h0, 32'hA5000001);
        tick(3);
        chk({29'h0, irq, f_all, f_proc}, 32'h00000005, "error before reset");
        do_reset();
        chk({29'h0, irq, f_all, f_proc}, 32'h00000000, "outputs after reset");
        rd_chk(4'h8, 32'h00000000, "flags after reset");
        wr_reg(4'h4, MODE_B);
        run_slow(1600);
        chk({20'h00000, count}, 32'h00000008, "disabled holds");
        rd_chk(4'h8, 32'h00000000, "no underflow disabled");
        wr_reg(4'h0, 32'hA5000001);
        tick(3);
        chk({29'h0, irq, f_all, f_proc}, 32'h00000003, "full reset request");
        chk({16'h0000, n_sys, n_proc}, 32'h00000101, "partner both resets");
        $display("test disabled done");
        report_and_stop();
    end
endmodule : wwdt_top_tb
`default_nettype wire
